// [src/dldc_chan.sv]
// one channel's ramp, settle and measure sequencer
`include "dldc_map.svh"
`default_nettype none
module dldc_chan
  import dldc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_ramp_dbl,
  input wire logic i_settle_dbl,
  input wire logic i_lo_en,
  input wire logic [3:0] i_threshold,
  input wire dldc_meas_s i_meas,
  output logic o_busy,
  output logic o_ramp,
  output logic o_settle,
  output logic o_meas,
  output logic o_lo_en,
  output logic [3:0] o_result,
  output logic o_lo_result
);
  dldc_chan_s s_r; // registered state
  dldc_chan_s s_nxt; // next state

  // sequencer next state
  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.phase)
      DLDC_IDLE:
      begin
        // launch a run, ramp length chosen now
        if (i_start)
        begin
          s_nxt.phase = DLDC_RAMP;
          s_nxt.cnt = i_ramp_dbl ? 16'(2 * `DLDC_RAMP_CYC - 1)
                                 : 16'(`DLDC_RAMP_CYC - 1);
          s_nxt.lo_en = i_lo_en;
        end
      end
      DLDC_RAMP:
      begin
        // ramp done, settle length chosen now
        if (s_r.cnt == 16'h0000)
        begin
          s_nxt.phase = DLDC_SETTLE;
          s_nxt.cnt = i_settle_dbl ? 16'(2 * `DLDC_SETTLE_CYC - 1)
                                   : 16'(`DLDC_SETTLE_CYC - 1);
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
      DLDC_SETTLE:
      begin
        // settle done, sample next
        if (s_r.cnt == 16'h0000)
        begin
          s_nxt.phase = DLDC_MEAS;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
      DLDC_MEAS:
      begin
        // capture outcome at completion
        s_nxt.result = {i_meas.s2g,
                        i_meas.s2p,
                        i_meas.open,
                        i_meas.res_code < i_threshold};
        s_nxt.lo_result = s_r.lo_en & i_meas.line_out;
        s_nxt.phase = DLDC_IDLE;
      end
    endcase
    // abort beats any phase, results kept
    if (i_abort)
    begin
      s_nxt.phase = DLDC_IDLE;
      s_nxt.cnt = 16'h0000;
    end
    // flop copies of the phase for outputs
    s_nxt.busy = (s_nxt.phase != DLDC_IDLE);
    s_nxt.ramping = (s_nxt.phase == DLDC_RAMP);
    s_nxt.settling = (s_nxt.phase == DLDC_SETTLE);
    s_nxt.meas = (s_nxt.phase == DLDC_MEAS);
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs from state flops, line-out enable is the lo_en flop gated by the meas flop
  assign o_busy = s_r.busy;
  assign o_ramp = s_r.ramping;
  assign o_settle = s_r.settling;
  assign o_meas = s_r.meas;
  assign o_lo_en = s_r.meas & s_r.lo_en;
  assign o_result = s_r.result;
  assign o_lo_result = s_r.lo_result;
endmodule
`default_nettype wire

// [src/dldc_map.svh]
// register map, field positions, reset values and timing counts
// Operation
// - abort bit seven stops a running diagnostic
// - abort bit resets low and self-clears after abort
// - bit six doubles the ramp phase length
// - bit five doubles the settle phase length
// - bit one includes line-output detection in runs
// - skip low: auto start on leaving hi-z, faults
// - skip high: no automatic diagnostic starts
// - threshold nibble in half-ohm steps, 0.5 to 5
// - 0x0A holds channel 1/2 thresholds, reset 0x11
// - 0x0B holds channel 3/4 thresholds, reset 0x11
// - 0x0C read-only channel 1/2 results, reset 0x00
// - nibble top bit flags short to ground
// - nibble second bit flags short to power
// - nibble third bit flags open load
// - nibble low bit flags shorted load below threshold
// - state code 11 enters dc load diagnostics
`ifndef DLDC_MAP_SVH
`define DLDC_MAP_SVH

// register addresses
`define DLDC_ADDR_CTRL_MAIN 8'h09
`define DLDC_ADDR_THR_CH12 8'h0A
`define DLDC_ADDR_THR_CH34 8'h0B
`define DLDC_ADDR_RES_CH12 8'h0C

// reset values
`define DLDC_RST_CTRL_MAIN 8'h00
`define DLDC_RST_THR 8'h11
`define DLDC_RST_RES 4'h0
`define DLDC_RST_CH_STATE 8'h55

// control register bit positions
`define DLDC_BIT_ABORT 7
`define DLDC_BIT_RAMP_DBL 6
`define DLDC_BIT_SETTLE_DBL 5
`define DLDC_BIT_LO_EN 1
`define DLDC_BIT_SKIP 0

// channel state codes
`define DLDC_STATE_HIZ 2'h1
`define DLDC_STATE_DIAG 2'h3

// timing: clock period and phase times in ns
`define DLDC_CLK_PERIOD_NS 10
`define DLDC_RAMP_TIME_NS 10000
`define DLDC_SETTLE_TIME_NS 5000
// least times round up to whole cycles
`define DLDC_RAMP_CYC \
  ((`DLDC_RAMP_TIME_NS + `DLDC_CLK_PERIOD_NS - 1) / `DLDC_CLK_PERIOD_NS)
`define DLDC_SETTLE_CYC \
  ((`DLDC_SETTLE_TIME_NS + `DLDC_CLK_PERIOD_NS - 1) / `DLDC_CLK_PERIOD_NS)

`endif

// [src/dldc_pkg.sv]
// types shared by the dc load diagnostic control block
`default_nettype none
package dldc_pkg;
  // diagnostic sequencer phases
  typedef enum logic [1:0] {DLDC_IDLE, DLDC_RAMP, DLDC_SETTLE, DLDC_MEAS}
    dldc_phase_e;
  // analog measurement outcome for one channel
  typedef struct packed {
    logic s2g; // output shorted to ground
    logic s2p; // output shorted to power
    logic open; // open load
    logic line_out; // line output seen
    logic [3:0] res_code; // load resistance, half-ohm steps
  } dldc_meas_s;
  // per-channel sequencer state
  typedef struct packed {
    dldc_phase_e phase;
    logic [15:0] cnt;
    logic busy;
    logic ramping;
    logic settling;
    logic meas;
    logic lo_en;
    logic [3:0] result;
    logic lo_result;
  } dldc_chan_s;
  // top-level register state
  typedef struct packed {
    logic abort;
    logic ramp_dbl;
    logic settle_dbl;
    logic lo_en;
    logic skip;
    logic [7:0] thr12;
    logic [7:0] thr34;
    logic [7:0] rdata;
    logic [7:0] prev_state;
    logic [3:0] busy;
    logic [3:0] ramp;
    logic [3:0] settle;
    logic [3:0] meas;
    logic [3:0] lo_en_out;
    logic [3:0] lo_res;
    logic [7:0] res34;
  } dldc_top_s;
endpackage
`default_nettype wire

// [src/dldc_top.sv]
// dc load diagnostic control registers and four channel sequencers
`include "dldc_map.svh"
`default_nettype none
module dldc_top
  import dldc_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  input wire logic [7:0] I_CH_STATE,
  input wire logic [3:0] I_CH_FAULT,
  input wire dldc_meas_s [3:0] I_MEAS,
  output logic [3:0] O_DIAG_BUSY,
  output logic [3:0] O_RAMP_ACTIVE,
  output logic [3:0] O_SETTLE_ACTIVE,
  output logic [3:0] O_MEAS_STROBE,
  output logic [3:0] O_LINE_OUT_EN,
  output logic [3:0] O_LINE_OUT_RESULT,
  output logic [7:0] O_RESULT_CH34
);
  dldc_top_s s_r; // registered state
  dldc_top_s s_nxt; // next state

  // per-channel wires from the sequencers
  logic [3:0] start; // launch request per channel
  logic [3:0] ch_busy; // sequencer running
  logic [3:0] ch_ramp; // ramp phase
  logic [3:0] ch_settle; // settle phase
  logic [3:0] ch_meas; // sampling cycle
  logic [3:0] ch_lo_en; // line-out sensing
  logic [3:0] ch_lo_res; // line-out result
  logic [3:0] ch_res [4]; // result nibbles, index 0 is channel 1
  logic [3:0] ch_thr [4]; // thresholds, index 0 is channel 1
  logic write_ctrl; // write strobe for control register

  // threshold nibble for channel index, 0 is channel 1
  function automatic logic [3:0] thr_of(input logic [7:0] thr12,
                                        input logic [7:0] thr34,
                                        input int idx);
    logic [7:0] pair;
    pair = (idx < 2) ? thr12 : thr34;
    // even index sits in the high nibble
    return (idx % 2 == 0) ? pair[7:4] : pair[3:0];
  endfunction

  // two-bit state code for channel index, 0 is channel 1
  function automatic logic [1:0] state_of(input logic [7:0] st,
                                          input int idx);
    return st[7 - 2 * idx -: 2];
  endfunction

  // read mux over the mapped registers
  function automatic logic [7:0] read_of(input dldc_top_s s,
                                         input logic [7:0] addr,
                                         input logic [3:0] res1,
                                         input logic [3:0] res2);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      `DLDC_ADDR_CTRL_MAIN:
      begin
        d[`DLDC_BIT_ABORT] = s.abort;
        d[`DLDC_BIT_RAMP_DBL] = s.ramp_dbl;
        d[`DLDC_BIT_SETTLE_DBL] = s.settle_dbl;
        d[`DLDC_BIT_LO_EN] = s.lo_en;
        d[`DLDC_BIT_SKIP] = s.skip;
      end
      `DLDC_ADDR_THR_CH12:
      begin
        d = s.thr12;
      end
      `DLDC_ADDR_THR_CH34:
      begin
        d = s.thr34;
      end
      `DLDC_ADDR_RES_CH12:
      begin
        d = {res1, res2};
      end
      default:
      begin
        // unmapped addresses read zero
        d = 8'h00;
      end
    endcase
    return d;
  endfunction

  assign write_ctrl = I_REG_WR && (I_REG_ADDR == `DLDC_ADDR_CTRL_MAIN);

  // start conditions per channel
  always_comb
  begin
    logic [1:0] now_st;
    logic [1:0] was_st;
    now_st = 2'h0;
    was_st = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      now_st = state_of(I_CH_STATE, i);
      was_st = state_of(s_r.prev_state, i);
      ch_thr[i] = thr_of(s_r.thr12, s_r.thr34, i);
      // host asks for diagnostics explicitly
      start[i] = (now_st == `DLDC_STATE_DIAG) &&
                 (was_st != `DLDC_STATE_DIAG);
      // automatic starts unless skipped
      if (!s_r.skip)
      begin
        if ((was_st == `DLDC_STATE_HIZ) && (now_st != `DLDC_STATE_HIZ))
        begin
          start[i] = 1'b1;
        end
        if (I_CH_FAULT[i])
        begin
          start[i] = 1'b1;
        end
      end
      // no launch while abort is being carried out
      if (s_r.abort)
      begin
        start[i] = 1'b0;
      end
    end
  end

  // four channel sequencers
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      dldc_chan u_chan (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_start(start[g]),
        .i_abort(s_r.abort),
        .i_ramp_dbl(s_r.ramp_dbl),
        .i_settle_dbl(s_r.settle_dbl),
        .i_lo_en(s_r.lo_en),
        .i_threshold(ch_thr[g]),
        .i_meas(I_MEAS[g]),
        .o_busy(ch_busy[g]),
        .o_ramp(ch_ramp[g]),
        .o_settle(ch_settle[g]),
        .o_meas(ch_meas[g]),
        .o_lo_en(ch_lo_en[g]),
        .o_result(ch_res[g]),
        .o_lo_result(ch_lo_res[g])
      );
    end
  endgenerate

  // register file next state
  always_comb
  begin
    s_nxt = s_r;
    // abort lasts one cycle, then reads zero
    s_nxt.abort = 1'b0;
    // control register write
    if (write_ctrl)
    begin
      s_nxt.abort = I_REG_WDATA[`DLDC_BIT_ABORT];
      s_nxt.ramp_dbl = I_REG_WDATA[`DLDC_BIT_RAMP_DBL];
      s_nxt.settle_dbl = I_REG_WDATA[`DLDC_BIT_SETTLE_DBL];
      s_nxt.lo_en = I_REG_WDATA[`DLDC_BIT_LO_EN];
      s_nxt.skip = I_REG_WDATA[`DLDC_BIT_SKIP];
    end
    // threshold registers
    if (I_REG_WR && (I_REG_ADDR == `DLDC_ADDR_THR_CH12))
    begin
      s_nxt.thr12 = I_REG_WDATA;
    end
    if (I_REG_WR && (I_REG_ADDR == `DLDC_ADDR_THR_CH34))
    begin
      s_nxt.thr34 = I_REG_WDATA;
    end
    // result register ignores writes
    // read data latched on the read strobe
    if (I_REG_RD)
    begin
      s_nxt.rdata = read_of(s_r, I_REG_ADDR, ch_res[0], ch_res[1]);
    end
    // remember state codes for edge detection
    s_nxt.prev_state = I_CH_STATE;
    // output copies of sequencer status
    s_nxt.busy = ch_busy;
    s_nxt.ramp = ch_ramp;
    s_nxt.settle = ch_settle;
    s_nxt.meas = ch_meas;
    s_nxt.lo_en_out = ch_lo_en;
    s_nxt.lo_res = ch_lo_res;
    s_nxt.res34 = {ch_res[2], ch_res[3]};
  end

  // register file flops
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s_r <= '0;
      s_r.abort <= 1'(`DLDC_RST_CTRL_MAIN >> `DLDC_BIT_ABORT);
      s_r.thr12 <= `DLDC_RST_THR;
      s_r.thr34 <= `DLDC_RST_THR;
      s_r.prev_state <= `DLDC_RST_CH_STATE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs from flops
  assign O_REG_RDATA = s_r.rdata;
  assign O_DIAG_BUSY = s_r.busy;
  assign O_RAMP_ACTIVE = s_r.ramp;
  assign O_SETTLE_ACTIVE = s_r.settle;
  assign O_MEAS_STROBE = s_r.meas;
  assign O_LINE_OUT_EN = s_r.lo_en_out;
  assign O_LINE_OUT_RESULT = s_r.lo_res;
  assign O_RESULT_CH34 = s_r.res34;
endmodule
`default_nettype wire

// [verification/dldc_checker.sv]
// assertion checker for the diagnostic control block
`default_nettype none
module dldc_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic [7:0] I_CH_STATE,
  input wire logic [3:0] I_CH_FAULT,
  input wire logic [3:0] O_DIAG_BUSY,
  input wire logic [3:0] O_RAMP_ACTIVE,
  input wire logic [3:0] O_SETTLE_ACTIVE,
  input wire logic [3:0] O_MEAS_STROBE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr09; // control register write
  logic [7:0] ctrl_m; // control shadow, abort dropped
  logic [7:0] thr12_m; // threshold shadow
  logic [7:0] prev_st; // channel codes one cycle back
  logic [11:0] rcnt; // channel 1 ramp length
  logic [11:0] scnt; // channel 1 settle length
  assign wr09 = I_REG_WR && I_REG_ADDR == 8'h09;
  // shadows and phase counters
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      ctrl_m <= 8'h00;
      thr12_m <= 8'h11;
      prev_st <= 8'h55;
      rcnt <= 12'h000;
      scnt <= 12'h000;
    end
    else
    begin
      if (wr09)
        ctrl_m <= I_REG_WDATA & 8'h63;
      if (I_REG_WR && I_REG_ADDR == 8'h0A)
        thr12_m <= I_REG_WDATA;
      prev_st <= I_CH_STATE;
      rcnt <= O_RAMP_ACTIVE[0] ? rcnt + 12'h001 : 12'h000;
      scnt <= O_SETTLE_ACTIVE[0] ? scnt + 12'h001 : 12'h000;
    end
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  // settle phase handing over to the measure cycle
  sequence s_settle_done;
    O_SETTLE_ACTIVE[0] ##1 O_MEAS_STROBE[0];
  endsequence
  sequence s_ctrl_read;
    I_REG_RD && !I_REG_WR && I_REG_ADDR == 8'h09 && !$past(I_REG_WR);
  endsequence
  a_abort_stops_run: assert property (
    wr09 && I_REG_WDATA[7] |-> ##[1:4] O_DIAG_BUSY == 4'h0)
    else $error("busy held after abort");
  a_ctrl_self_clear: assert property (
    s_ctrl_read |=> O_REG_RDATA == $past(ctrl_m))
    else $error("control readback wrong");
  a_thr_readback: assert property (
    I_REG_RD && I_REG_ADDR == 8'h0A |=> O_REG_RDATA == $past(thr12_m))
    else $error("threshold readback wrong");
  a_ramp_length: assert property (
    $fell(O_RAMP_ACTIVE[0]) && O_SETTLE_ACTIVE[0] |->
    rcnt == (ctrl_m[6] ? 12'h7D0 : 12'h3E8))
    else $error("ramp length wrong");
  a_settle_length: assert property (
    $fell(O_SETTLE_ACTIVE[0]) && O_MEAS_STROBE[0] |->
    scnt == (ctrl_m[5] ? 12'h3E8 : 12'h1F4))
    else $error("settle length wrong");
  a_meas_single: assert property (
    s_settle_done |=> !O_MEAS_STROBE[0])
    else $error("measure strobe too long");
  a_diag_entry: assert property (
    !O_DIAG_BUSY[0] && I_CH_STATE[7:6] == 2'h3 && prev_st[7:6] != 2'h3
    |-> ##[2:3] O_DIAG_BUSY[0])
    else $error("diagnostic state did not start a run");
  a_skip_holds: assert property (
    ctrl_m[0] && I_CH_FAULT[0] && !O_DIAG_BUSY[0] &&
    I_CH_STATE[7:6] != 2'h3 && prev_st[7:6] != 2'h3 |-> ##3 !O_DIAG_BUSY[0])
    else $error("run started while skipped");
endmodule
`default_nettype wire

// [verification/dldc_host.sv]
// host model driving the register port
`default_nettype none
module dldc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port at time zero
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // one write; released data lines show the inverse, address held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  // one read; data stands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// [verification/dldc_top_tb.sv]
// testbench for the diagnostic control block
`default_nettype none
module dldc_top_tb;
  import dldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr, rd;
  logic [7:0] addr, wdata, rdata, state, res34;
  logic [3:0] fault, busy, ramp, settle, strobe, lo_en, lo_res;
  dldc_meas_s [3:0] meas; // analog outcome per channel
  int bad_count = 0;
  int total_checks = 0;
  dldc_host i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  dldc_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .I_CH_STATE(state), .I_CH_FAULT(fault),
    .I_MEAS(meas), .O_DIAG_BUSY(busy), .O_RAMP_ACTIVE(ramp),
    .O_SETTLE_ACTIVE(settle), .O_MEAS_STROBE(strobe),
    .O_LINE_OUT_EN(lo_en), .O_LINE_OUT_RESULT(lo_res),
    .O_RESULT_CH34(res34));
  // core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare one value
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("register", exp, d);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one run entered through the diagnostic state code
  task automatic run(input logic [7:0] res, input logic [3:0] lo,
    output int n);
    n = 0;
    state <= 8'hFF;
    while (strobe[0] !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    chk("line out enable", {4'h0, lo}, {4'h0, lo_en});
    repeat (4) @(posedge clk);
    state <= 8'h55;
    rchk(8'h0C, res);
    chk("result ch34", res, res34);
    chk("line out result", {4'h0, lo}, {4'h0, lo_res});
  endtask
  task automatic t_reset_vals();
    rchk(8'h09, 8'h00);
    rchk(8'h0A, 8'h11);
    rchk(8'h0B, 8'h11);
    i_host.wr(8'h0C, 8'hFF);
    rchk(8'h0C, 8'h00);
    rchk(8'h20, 8'h00);
  endtask
  task automatic t_run_normal();
    int n;
    i_host.wr(8'h0A, 8'h35);
    i_host.wr(8'h0B, 8'h35);
    i_host.wr(8'h09, 8'h03);
    rchk(8'h0B, 8'h35);
    meas <= {8'h55, 8'hB2, 8'h55, 8'hB2};
    run(8'hB4, 4'hF, n);
    chk("normal length", 8'h01, {7'h0, n > 1400 && n < 1600});
  endtask
  task automatic t_run_double();
    int n;
    i_host.wr(8'h09, 8'h60);
    rchk(8'h09, 8'h60);
    meas <= {8'hA4, 8'h44, 8'hA4, 8'h44};
    run(8'h4B, 4'h0, n);
    chk("double length", 8'h01, {7'h0, n > 2900 && n < 3100});
  endtask
  // skipped and automatic starts from hi-z exit and fault
  task automatic t_auto();
    i_host.wr(8'h09, 8'h01);
    state <= 8'h15;
    fault <= 4'hF;
    @(posedge clk);
    fault <= 4'h0;
    repeat (4) @(posedge clk);
    chk("busy skipped", 8'h00, {4'h0, busy});
    state <= 8'h55;
    i_host.wr(8'h09, 8'h00);
    state <= 8'h15;
    fault <= 4'h2;
    @(posedge clk);
    fault <= 4'h0;
    repeat (3) @(posedge clk);
    chk("busy automatic", 8'h03, {4'h0, busy});
  endtask
  task automatic t_abort();
    i_host.wr(8'h09, 8'h80);
    repeat (3) @(posedge clk);
    chk("busy aborted", 8'h00, {4'h0, busy});
    rchk(8'h09, 8'h00);
    rchk(8'h0C, 8'h4B);
  endtask
  // hang guard, about four times the expected run
  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    state = 8'h55;
    fault = 4'h0;
    meas = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_run_normal();
    t_run_double();
    t_auto();
    t_abort();
    test_done();
  end
endmodule
bind dldc_top dldc_checker i_chk (.I_CORE_CLK, .I_RST, .I_REG_ADDR,
  .I_REG_WR, .I_REG_RD, .I_REG_WDATA, .O_REG_RDATA, .I_CH_STATE,
  .I_CH_FAULT, .O_DIAG_BUSY, .O_RAMP_ACTIVE, .O_SETTLE_ACTIVE,
  .O_MEAS_STROBE);
`default_nettype wire
